// file: bench/host_port_model.sv
`timescale 1ns/1ps
module host_port_model
  import vib_pkg::*;
(
  input wire logic clk,
  output port_pins_t port_pins
);
  initial port_pins = PINS_RST;

  // host sees the port at its configured base
  localparam logic [15:0] PORT_BASE = 16'h0378;

  // software paced, with a fixed wait after each change
  // every pin change is held at least 9 cycles, past the sync depth
  task automatic put(input logic [CTRL_W-1:0] c, input logic [DATA_W-1:0] d);
    @(negedge clk);
    port_pins = '{data: d, ctrl_n: c};
    repeat (8) @(negedge clk);
  endtask : put

  // register write; control bits are inverted at the pins
  task automatic out_reg(input logic [15:0] addr, input logic [DATA_W-1:0] val);
    port_pins_t p;
    p = port_pins;
    if (addr == PORT_BASE + 16'(OFS_DATA)) begin
      p.data = val;
    end else if (addr == PORT_BASE + 16'(OFS_CONTROL)) begin
      p.ctrl_n = ~val[CTRL_W-1:0];
    end
    put(p.ctrl_n, p.data);
  endtask : out_reg

  task automatic refresh(input logic [1:0] mask, input logic [NUM_OUT-1:0] v);
    if (mask[0]) begin
      put(4'he, port_pins.data);
      put(4'he, v[7:0]);
      put(4'hf, v[7:0]);
    end
    if (mask[1]) begin
      put(4'hd, port_pins.data);
      put(4'hd, v[15:8]);
      put(4'hf, v[15:8]);
    end
  endtask : refresh

  // data changed only while its select is high
  // half period scaled to 18 cycles instead of a 1 ms tick
  task automatic pwm(input int periods, input logic [7:0][3:0] da,
                     input logic [7:0][3:0] db);
    logic [DATA_W-1:0] pa;
    logic [DATA_W-1:0] pb;
    for (int k = 0; k < 10 * periods; k++) begin
      for (int b = 0; b < DATA_W; b++) begin
        pa[b] = (k % 10) < da[b];
        pb[b] = (k % 10) < db[b];
      end
      put(4'he, port_pins.data);
      put(4'he, pa);
      put(4'hd, pa);
      put(4'hd, pb);
    end
    put(4'hf, pb);
  endtask : pwm
endmodule : host_port_model

// file: bench/sixteen_channel_latched_pwm_test.sv
`timescale 1ns/1ps
module sixteen_channel_latched_pwm_test
  import vib_pkg::*;
;
  typedef struct packed {
    logic [1:0] mask;
    logic [15:0] v;
    logic [15:0] exp;
  } row_t;
  localparam logic [31:0] DA = 32'h6194_05a3;
  localparam logic [31:0] DB = 32'h0a15_7940;
  logic clk;
  logic rstn;
  port_pins_t port_pins;
  status_pins_t status_pins;
  logic [NUM_OUT-1:0] vibrator_drive_line;
  logic [2*NUM_OUT-1:0] intensity_level;
  logic pwm_mode;
  int n_mismatch;
  int n_tests;
  logic [31:0] exp_lvl;
  // unloaded latch rows show the other half held
  row_t rows [8] = '{
    '{2'h3, 16'ha5c3, 16'ha5c3}, '{2'h1, 16'hffff, 16'ha5ff},
    '{2'h2, 16'h0000, 16'h00ff}, '{2'h3, 16'hffff, 16'hffff},
    '{2'h3, 16'h0000, 16'h0000}, '{2'h2, 16'h8001, 16'h8000},
    '{2'h1, 16'h0001, 16'h8001}, '{2'h3, 16'h5a3c, 16'h5a3c}};

  vib_latch_board #(.STALL_LIMIT(200)) u_vib_latch_board (
    .clk(clk), .rstn(rstn), .port_pins(port_pins), .status_pins(status_pins),
    .vibrator_drive_line(vibrator_drive_line), .intensity_level(intensity_level),
    .pwm_mode(pwm_mode));
  host_port_model u_host_port_model (.clk(clk), .port_pins(port_pins));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [1:0] lvl(input logic [3:0] hits);
    return (hits == 4'h0) ? LVL_OFF : (hits <= 4'h4) ? LVL_LOW :
           (hits <= 4'h9) ? LVL_HIGH : LVL_FULL;
  endfunction : lvl

  function automatic logic [31:0] plain_lvl(input logic [15:0] v);
    logic [31:0] r;
    for (int i = 0; i < 16; i++) r[2*i +: 2] = v[i] ? LVL_FULL : LVL_OFF;
    return r;
  endfunction : plain_lvl

  task automatic err(input string what);
    n_mismatch++;
    $display("[ERR] %0t %s", $time, what);
  endtask : err

  task automatic chk_drive(input logic [15:0] exp);
    n_tests++;
    if (vibrator_drive_line !== exp) err("drive lines differ");
  endtask : chk_drive

  task automatic chk_lvl(input logic [31:0] exp);
    n_tests++;
    if (intensity_level !== exp) err("intensity differs");
  endtask : chk_lvl

  task automatic chk_flag(input logic [4:0] got, input logic [4:0] exp);
    n_tests++;
    if (got !== exp) err("flag or status differs");
  endtask : chk_flag

  task automatic end_of_test;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #100us;
    err("run timed out");
    end_of_test();
  end

  task automatic chk_reset;
    chk_drive(16'h0000);
    chk_lvl(32'h0);
    chk_flag({4'h0, pwm_mode}, 5'h00);
    chk_flag(status_pins, 5'h0b);
  endtask : chk_reset

  initial begin
    n_mismatch = 0;
    n_tests = 0;
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    chk_reset();
    rstn = 1'b1;
    foreach (rows[i]) begin
      u_host_port_model.refresh(rows[i].mask, rows[i].v);
      chk_drive(rows[i].exp);
      chk_lvl(plain_lvl(rows[i].exp));
      chk_flag({4'h0, pwm_mode}, 5'h00);
    end
    // register writes: data alone, both selects together, then init clears
    u_host_port_model.refresh(2'h3, 16'hffff);
    u_host_port_model.out_reg(16'h0378, 8'h3c);
    chk_drive(16'hffff);
    u_host_port_model.out_reg(16'h037a, 8'h03);
    u_host_port_model.out_reg(16'h037a, 8'h00);
    chk_drive(16'h3c3c);
    u_host_port_model.out_reg(16'h037a, 8'h04);
    u_host_port_model.out_reg(16'h037a, 8'h00);
    chk_drive(16'h0000);
    // second reset in mid-run
    u_host_port_model.refresh(2'h3, 16'ha5c3);
    @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    chk_reset();
    rstn = 1'b1;
    u_host_port_model.pwm(3, DA, DB);
    repeat (10) @(negedge clk);
    for (int b = 0; b < 8; b++) begin
      exp_lvl[2*b +: 2] = lvl(DA[4*b +: 4]);
      exp_lvl[16 + 2*b +: 2] = lvl(DB[4*b +: 4]);
    end
    chk_flag({4'h0, pwm_mode}, 5'h01);
    chk_lvl(exp_lvl);
    chk_drive(16'h4002);
    // selects stopped: stall limit drops back to plain
    repeat (300) @(negedge clk);
    chk_flag({4'h0, pwm_mode}, 5'h00);
    chk_lvl(plain_lvl(16'h4002));
    end_of_test();
  end
endmodule : sixteen_channel_latched_pwm_test

// file: logic/data_latch.sv
`timescale 1ns/1ps
module data_latch
  import vib_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic sel,
  input wire logic clr,
  input wire logic [DATA_W-1:0] d,
  output logic [DATA_W-1:0] q
);
  logic [DATA_W-1:0] q_ff;

  assign q = q_ff;

  // clocked stand-in for a transparent latch: follows while selected
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= LATCH_RST;
    end else if (clr) begin
      q_ff <= LATCH_RST;
    end else if (sel) begin
      q_ff <= d;
    end
  end
endmodule : data_latch

// file: logic/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 12,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;
  logic [W-1:0] nxt_out;

  // a bit moves only once stages two and three agree
  assign nxt_out = (s2_ff & ~(s2_ff ^ s3_ff)) | (out_ff & (s2_ff ^ s3_ff));
  assign clean = out_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= RST;
      s2_ff <= RST;
      s3_ff <= RST;
      out_ff <= RST;
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end
endmodule : pin_sync

// file: logic/vib_latch_board.sv
`timescale 1ns/1ps
module vib_latch_board
  import vib_pkg::*;
#(
  parameter int unsigned STALL_LIMIT = STALL_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire port_pins_t port_pins,
  output status_pins_t status_pins,
  output logic [NUM_OUT-1:0] vibrator_drive_line,
  output logic [2*NUM_OUT-1:0] intensity_level,
  output logic pwm_mode
);
  port_pins_t pins_s;
  logic [NUM_LATCH-1:0] sel;
  logic [NUM_LATCH-1:0] sel_d_ff;
  logic [NUM_LATCH-1:0] fall;
  logic [NUM_LATCH-1:0] wrap;
  logic [3:0] per_cnt_ff [NUM_LATCH];
  logic [DATA_W-1:0] latch_q [NUM_LATCH];
  logic [DATA_W-1:0] first_latch_output;
  logic [DATA_W-1:0] second_latch_output;
  logic init_clr;
  logic [NUM_OUT-1:0] drive_ff;
  logic [3:0] hit_cnt_ff [NUM_OUT];
  logic [3:0] hits [NUM_OUT];
  logic [1:0] lvl_ff [NUM_OUT];
  logic [3:0] bfall_cnt_ff;
  logic [3:0] bfall_total;
  logic qualify;
  logic [31:0] stall_cnt_ff;
  logic stall_hit;
  mode_t mode_ff;
  mode_t nxt_mode;
  status_pins_t status_ff;
  logic pwm_ff;
  logic seen_sel_ff;

  pin_sync #(
    .W(SYNC_W),
    .RST(PINS_RST)
  ) u_pin_sync (
    .clk(clk),
    .rstn(rstn),
    .raw(port_pins),
    .clean(pins_s)
  );

  assign sel[0] = ~pins_s.ctrl_n[CTL_STROBE];
  assign sel[1] = ~pins_s.ctrl_n[CTL_AUTOLF];
  assign init_clr = ~pins_s.ctrl_n[CTL_INIT];
  assign fall = sel_d_ff & ~sel;
  // a silent host must not leave stale pwm levels
  assign stall_hit = stall_cnt_ff >= STALL_LIMIT;

  genvar j;
  genvar i;
  generate
    for (j = 0; j < NUM_LATCH; j++) begin : g_latch
      data_latch u_data_latch (
        .clk(clk),
        .rstn(rstn),
        .sel(sel[j]),
        .clr(init_clr),
        .d(pins_s.data),
        .q(latch_q[j])
      );
      assign wrap[j] = fall[j] && (per_cnt_ff[j] == PWM_SEL_CYCLES - 4'h1);
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          per_cnt_ff[j] <= 4'h0;
        end else if (stall_hit || wrap[j]) begin
          per_cnt_ff[j] <= 4'h0;
        end else if (fall[j]) begin
          per_cnt_ff[j] <= per_cnt_ff[j] + 4'h1;
        end
      end
    end
  endgenerate

  assign first_latch_output = latch_q[0];
  assign second_latch_output = latch_q[1];

  function automatic logic [1:0] lvl_of(input logic [3:0] h);
    if (h == 4'h0) begin
      return LVL_OFF;
    end else if (h <= LVL1_MAX_HITS) begin
      return LVL_LOW;
    end else if (h <= LVL2_MAX_HITS) begin
      return LVL_HIGH;
    end
    return LVL_FULL;
  endfunction : lvl_of

  // b must fall almost every a-cycle for the pair to count as pwm clocks
  assign bfall_total = bfall_cnt_ff + {3'h0, fall[1]};
  assign qualify = bfall_total >= PWM_QUALIFY;

  generate
    for (i = 0; i < NUM_OUT; i++) begin : g_chan
      localparam int L = i / DATA_W;
      assign hits[i] = hit_cnt_ff[i] + {3'h0, fall[L] & latch_q[L][i % DATA_W]};
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          hit_cnt_ff[i] <= 4'h0;
        end else if (stall_hit || wrap[L]) begin
          hit_cnt_ff[i] <= 4'h0;
        end else begin
          hit_cnt_ff[i] <= hits[i];
        end
      end
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          lvl_ff[i] <= LVL_OFF;
        end else if (wrap[L] && (mode_ff == MODE_PWM || qualify)) begin
          lvl_ff[i] <= lvl_of(hits[i]);
        end else if (mode_ff != MODE_PWM) begin
          lvl_ff[i] <= drive_ff[i] ? LVL_FULL : LVL_OFF;
        end
      end
      assign intensity_level[2*i+1:2*i] = lvl_ff[i];
    end
  endgenerate

  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      MODE_IDLE: begin
        if (|sel) begin
          nxt_mode = MODE_PLAIN;
        end
      end
      MODE_PLAIN: begin
        if (wrap[0] && qualify) begin
          nxt_mode = MODE_PWM;
        end
      end
      MODE_PWM: begin
        if (stall_hit || (wrap[0] && !qualify)) begin
          nxt_mode = MODE_PLAIN;
        end
      end
      default: begin
        nxt_mode = MODE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_d_ff <= '0;
      bfall_cnt_ff <= 4'h0;
      stall_cnt_ff <= 32'h0;
      mode_ff <= MODE_IDLE;
      pwm_ff <= 1'b0;
      seen_sel_ff <= 1'b0;
    end else begin
      sel_d_ff <= sel;
      bfall_cnt_ff <= (wrap[0] || stall_hit) ? 4'h0 : bfall_total;
      stall_cnt_ff <= (|fall) ? 32'h0 : (stall_hit ? stall_cnt_ff : stall_cnt_ff + 32'h1);
      mode_ff <= nxt_mode;
      pwm_ff <= (nxt_mode == MODE_PWM);
      seen_sel_ff <= seen_sel_ff | (|sel);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drive_ff <= '0;
      status_ff <= STATUS_RST;
    end else begin
      drive_ff <= {second_latch_output, first_latch_output};
      status_ff <= STATUS_RST;
    end
  end

  assign status_pins = status_ff;
  // eight data lines to sixteen drives
  assign vibrator_drive_line = drive_ff;
  assign pwm_mode = pwm_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_latch_follow;
    sel[0] && !init_clr |=> first_latch_output == $past(pins_s.data);
  endproperty
  a_latch_follow: assert property (p_latch_follow)
    else $error("first latch did not follow");

  property p_latch_hold;
    !sel[1] && !init_clr |=> $stable(second_latch_output);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("second latch changed unselected");

  property p_first_hold;
    !sel[0] && !init_clr |=> $stable(first_latch_output);
  endproperty
  a_first_hold: assert property (p_first_hold)
    else $error("first latch changed unselected");

  property p_same_data;
    sel[0] && sel[1] && !init_clr |=> first_latch_output == second_latch_output;
  endproperty
  a_same_data: assert property (p_same_data)
    else $error("latches saw different data");

  property p_sel_pin;
    !pins_s.ctrl_n[CTL_AUTOLF] && !init_clr |=> second_latch_output == $past(pins_s.data);
  endproperty
  a_sel_pin: assert property (p_sel_pin)
    else $error("second select pin ignored");

  property p_init;
    init_clr |=> first_latch_output == LATCH_RST ##1 vibrator_drive_line == '0;
  endproperty
  a_init: assert property (p_init)
    else $error("init pin did not clear outputs");

  property p_drive;
    ##1 vibrator_drive_line == $past({second_latch_output, first_latch_output});
  endproperty
  a_drive: assert property (p_drive)
    else $error("drive line not from latches");

  property p_reset_off;
    !seen_sel_ff |-> vibrator_drive_line == '0 && intensity_level == '0;
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("output on before first load");

  property p_plain_bin;
    mode_ff == MODE_PLAIN && !(wrap[0] && qualify)
      |=> intensity_level[1:0] == {2{$past(vibrator_drive_line[0])}};
  endproperty
  a_plain_bin: assert property (p_plain_bin)
    else $error("plain mode level not binary");

  property p_period;
    wrap[0] |=> per_cnt_ff[0] == 4'h0 && $past(per_cnt_ff[0]) == 4'h9;
  endproperty
  a_period: assert property (p_period)
    else $error("window not ten select cycles");

  property p_wrap_b;
    wrap[1] |=> per_cnt_ff[1] == 4'h0;
  endproperty
  a_wrap_b: assert property (p_wrap_b)
    else $error("second window did not restart");

  property p_stall;
    stall_hit && !(|fall) |=> per_cnt_ff[0] == 4'h0 && !pwm_mode;
  endproperty
  a_stall: assert property (p_stall)
    else $error("stalled selects kept pwm mode");

  property p_hits_range;
    hits[0] <= PWM_SEL_CYCLES && hits[8] <= PWM_SEL_CYCLES;
  endproperty
  a_hits_range: assert property (p_hits_range)
    else $error("duty count out of range");

  property p_level;
    mode_ff == MODE_PWM && wrap[0] && hits[0] == 4'h3 |=> intensity_level[1:0] == LVL_LOW;
  endproperty
  a_level: assert property (p_level)
    else $error("30 percent duty not level one");

  property p_lvl_full;
    mode_ff == MODE_PWM && wrap[0] && hits[1] == PWM_SEL_CYCLES
      |=> intensity_level[3:2] == LVL_FULL;
  endproperty
  a_lvl_full: assert property (p_lvl_full)
    else $error("full duty not level three");

  property p_lvl_off;
    mode_ff == MODE_PWM && wrap[1] && hits[8] == 4'h0
      |=> intensity_level[17:16] == LVL_OFF;
  endproperty
  a_lvl_off: assert property (p_lvl_off)
    else $error("zero duty not level zero");

  c_enter_pwm: cover property (mode_ff == MODE_PLAIN ##1 mode_ff == MODE_PWM);
  c_stall_exit: cover property (mode_ff == MODE_PWM ##1 mode_ff == MODE_PLAIN);
  c_plain_load: cover property (sel[0] ##[1:50] !sel[0] && sel[1]);
  c_init: cover property (init_clr && |drive_ff);
endmodule : vib_latch_board

// file: logic/vib_pkg.sv
package vib_pkg;
  localparam int DATA_W = 8;
  localparam int NUM_LATCH = 2;
  localparam int NUM_OUT = DATA_W * NUM_LATCH;
  localparam int CTRL_W = 4;
  localparam int SYNC_W = DATA_W + CTRL_W;
  // port register indices as seen from the host
  localparam logic [1:0] OFS_DATA = 2'h0;
  localparam logic [1:0] OFS_STATUS = 2'h1;
  localparam logic [1:0] OFS_CONTROL = 2'h2;
  // control pin positions (all active low at the connector)
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTOLF = 1;
  localparam int CTL_INIT = 2;
  localparam int CTL_SELPRN = 3;
  // packed so the fields land on status bits 7 down to 3
  typedef struct packed {
    logic busy;
    logic nack_n;
    logic paper_out;
    logic select;
    logic nerror_n;
  } status_pins_t;
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [CTRL_W-1:0] ctrl_n;
  } port_pins_t;
  localparam status_pins_t STATUS_RST = '{busy: 1'b0, nack_n: 1'b1, paper_out: 1'b0,
                                          select: 1'b1, nerror_n: 1'b1};
  localparam port_pins_t PINS_RST = '{data: 8'h00, ctrl_n: 4'hf};
  localparam logic [DATA_W-1:0] LATCH_RST = 8'h00;
  typedef enum logic [2:0] {
    MODE_IDLE = 3'b001,
    MODE_PLAIN = 3'b010,
    MODE_PWM = 3'b100
  } mode_t;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int STALL_TIME_US = 2000;
  localparam int STALL_CYCLES = STALL_TIME_US * 1000000 / CLK_PERIOD_PS;
  localparam logic [3:0] PWM_SEL_CYCLES = 4'ha;
  localparam logic [3:0] PWM_QUALIFY = 4'h9;
  localparam logic [3:0] LVL1_MAX_HITS = 4'h4;
  localparam logic [3:0] LVL2_MAX_HITS = 4'h9;
  localparam logic [1:0] LVL_OFF = 2'h0;
  localparam logic [1:0] LVL_LOW = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_FULL = 2'h3;
endpackage : vib_pkg
